// [spcz_ctl.sv]
/*
  Serial port control register zero and the behaviour it steers:
  unit, transmitter and receiver enables, word length, parity, mute
  mode with idle or address wake, break request and the combined
  interrupt request. Assumes the shifter and flag logic sit outside,
  report frames and break completion as one-cycle pulses, and keep
  the status flags as levels.
*/
// Decided for this implementation: the strobed register port.
//
// Summary of operation
// - Register at 0x0C, resets zero, word access.
// - Bit 11 picks idle or address wake.
// - Bit 10 enables parity, bit 9 odd.
// - Bit 8 gates parity fault interrupt.
// - Bit 7 gates transmit buffer free interrupt.
// - Bit 6 gates transmission done interrupt.
// - Bit 5 gates receive full or overflow.
// - Bit 4 gates quiet line interrupt.
// - Bit 3 enables transmitter when bit 13 is set.
// - Bit 2 enables receiver when bit 13 is set.
// - Bit 1 holds mute, software sets/clears.
// - Idle wake: idle frame clears mute.
// - Address wake: match clears, mismatch sets mute.
// - Bit 0 requests one break frame.
// - Hardware clears break bit when sent.
// - Compare low four bits with node address.
// - Parity replaces top transmitted data bit.
// - Idle frame is one frame time high.
//
`timescale 1ns/1ps
module spcz_ctl
  import spcz_pkg::*;
(
  input  wire logic                              mclk,
  input  wire logic                              reset,
  input  wire logic [spcz_pkg::ADDR_W-1:0]       reg_addr,
  input  wire logic [31:0]                       reg_wdata,
  input  wire logic                              reg_wr,
  input  wire logic                              reg_rd,
  output logic      [31:0]                       reg_rdata,
  input  wire spcz_pkg::spcz_flags_t             flags,
  input  wire logic [spcz_pkg::ADDR_MATCH_W-1:0] node_address,
  input  wire logic                              rx_line,
  input  wire logic                              bit_tick,
  input  wire logic                              rx_frame_valid,
  input  wire logic [spcz_pkg::DATA_W-1:0]       rx_frame_data,
  input  wire logic                              tx_data_load,
  input  wire logic [spcz_pkg::DATA_W-1:0]       tx_data_in,
  output logic      [spcz_pkg::DATA_W-1:0]       tx_word,
  input  wire logic                              break_done,
  output logic                                   break_send,
  output logic                                   transmitter_active,
  output logic                                   receiver_active,
  output logic                                   receiver_muted,
  output logic                                   word_length_nine,
  output logic                                   parity_on,
  output logic                                   parity_odd_select,
  output logic                                   idle_frame_seen,
  output logic                                   irq
);
  import spcz_pkg::*;

  // ----------------------------------------------------------------
  // Register decode
  // ----------------------------------------------------------------
  spcz_ctl_t   ctl_q;          // Control register
  spcz_ctl_t   ctl_d;          // Next control register
  spcz_ctl_t   wr_fields;      // Write data seen as fields
  logic [31:0] rdata_q;        // Read data register
  logic [31:0] rdata_d;        // Next read data
  logic        irq_q;          // Registered interrupt request
  logic        irq_d;          // Next interrupt request
  logic        hit_ctl;        // Address selects the control word
  logic        wr_ctl;         // Write to the control word
  logic        rd_ctl;         // Read of the control word

  // Only the one word address decodes; others read as zero
  assign hit_ctl   = reg_addr == OFS_CTL_ZERO;
  assign wr_ctl    = reg_wr && hit_ctl;
  assign rd_ctl    = reg_rd && hit_ctl;
  // Upper bits are kept zero by software and are not stored
  assign wr_fields = spcz_ctl_t'(reg_wdata[CTL_USED_W-1:0]);

  // ----------------------------------------------------------------
  // Enables
  // ----------------------------------------------------------------
  logic tx_en;    // Transmitter may run
  logic rx_en;    // Receiver may run

  // Each side has its own bit, both gated by the unit bit
  assign tx_en = ctl_q.unit_on && ctl_q.transmitter_on;
  assign rx_en = ctl_q.unit_on && ctl_q.receiver_on;

  // ----------------------------------------------------------------
  // Mute control
  // ----------------------------------------------------------------
  logic addr_match;   // Low bits of a frame equal the node address
  logic idle_pulse;   // Idle frame seen on the receive line
  logic hw_wake;      // Hardware clears mute
  logic hw_mute;      // Hardware sets mute
  logic rx_take;      // Frame accepted while receiving

  assign rx_take    = rx_frame_valid && rx_en;
  // Wake compare uses only the low nibble
  assign addr_match = rx_frame_data[ADDR_MATCH_W-1:0] == node_address;
  // Idle wake only in idle mode
  assign hw_wake    = (!ctl_q.wake_select && idle_pulse)
                   || (ctl_q.wake_select && rx_take && addr_match);
  // Mismatch sends the node back to sleep
  assign hw_mute    = ctl_q.wake_select && rx_take && !addr_match;

  // ----------------------------------------------------------------
  // Next control value
  // ----------------------------------------------------------------
  // Hardware mute events override a write in the same cycle, so a frame
  // that decides the mute state is never lost behind software.
  always_comb begin
    ctl_d = ctl_q;
    if (wr_ctl) begin
      ctl_d = wr_fields;
    end
    if (hw_wake) begin
      ctl_d.receiver_mute = 1'b0;
    end else if (hw_mute) begin
      ctl_d.receiver_mute = 1'b1;
    end
    // Completion clears, but a fresh request in that cycle stands
    if (break_done && !(wr_ctl && wr_fields.send_break_request)) begin
      ctl_d.send_break_request = 1'b0;
    end
  end

  // ----------------------------------------------------------------
  // Interrupt combine
  // ----------------------------------------------------------------
  logic pe_req;   // Parity fault request
  logic tb_req;   // Transmit buffer free request
  logic td_req;   // Transfer done request
  logic rb_req;   // Receive full or overflow request
  logic id_req;   // Quiet line request

  assign pe_req = ctl_q.parity_fault_irq_on && flags.parity_fault_flag;
  assign tb_req = ctl_q.tx_buffer_free_irq_on && flags.tx_buffer_free_flag;
  assign td_req = ctl_q.tx_done_irq_on && flags.transfer_done_flag;
  assign rb_req = ctl_q.rx_full_irq_on
               && (flags.rx_holding_full_flag || flags.overflow_fault_flag);
  assign id_req = ctl_q.quiet_line_irq_on && flags.quiet_line_flag;
  // Unit off silences every source
  assign irq_d  = ctl_q.unit_on && (pe_req || tb_req || td_req || rb_req || id_req);

  // Read data: control word or zero, valid only the next cycle
  assign rdata_d = rd_ctl ? {{(32 - CTL_USED_W){1'b0}}, ctl_q} : 32'h0000_0000;

  // ----------------------------------------------------------------
  // Registers
  // ----------------------------------------------------------------
  // Control word resets to all zeros
  always_ff @(posedge mclk) begin
    if (reset) begin
      ctl_q <= spcz_ctl_t'(CTL_ZERO_RESET[CTL_USED_W-1:0]);
    end else begin
      ctl_q <= ctl_d;
    end
  end

  // Read data and interrupt flops
  always_ff @(posedge mclk) begin
    if (reset) begin
      rdata_q <= 32'h0000_0000;
      irq_q   <= 1'b0;
    end else begin
      rdata_q <= rdata_d;
      irq_q   <= irq_d;
    end
  end

  // ----------------------------------------------------------------
  // Sub-blocks
  // ----------------------------------------------------------------
  // Transmit word former; load ignored while the transmitter is off
  spcz_parity u_parity (
    .mclk              (mclk),
    .reset             (reset),
    .parity_on         (ctl_q.parity_on),
    .parity_odd_select (ctl_q.parity_odd_select),
    .word_length_nine  (ctl_q.word_length_nine),
    .load              (tx_data_load && tx_en),
    .data_in           (tx_data_in),
    .word_out          (tx_word)
  );

  // Idle detector runs only with the receiver on
  spcz_idle u_idle (
    .mclk             (mclk),
    .reset            (reset),
    .enable           (rx_en),
    .word_length_nine (ctl_q.word_length_nine),
    .rx_line          (rx_line),
    .bit_tick         (bit_tick),
    .idle_seen        (idle_pulse)
  );

  // ----------------------------------------------------------------
  // Outputs
  // ----------------------------------------------------------------
  assign reg_rdata          = rdata_q;
  assign irq                = irq_q;
  // One break frame is asked for while the bit stands
  assign break_send         = tx_en && ctl_q.send_break_request;
  assign transmitter_active = tx_en;
  assign receiver_active    = rx_en;
  assign receiver_muted     = ctl_q.receiver_mute;
  assign word_length_nine   = ctl_q.word_length_nine;
  assign parity_on          = ctl_q.parity_on;
  assign parity_odd_select  = ctl_q.parity_odd_select;
  assign idle_frame_seen    = idle_pulse;

  // ----------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------
  // Write, one quiet bus cycle, then a read of the same word
  sequence s_write_ctl;
    wr_ctl ##1 !reg_wr ##1 (reg_rd && reg_addr == OFS_CTL_ZERO);
  endsequence

  // Hardware events in the write or gap cycle may change the word
  a_ctl_readback: assert property (@(posedge mclk) disable iff (reset)
    s_write_ctl ##0 (!$past(break_done) && !$past(hw_wake) && !$past(hw_mute)
      && !$past(break_done, 2) && !$past(hw_wake, 2) && !$past(hw_mute, 2))
    |=> reg_rdata == {18'h0, $past(reg_wdata[CTL_USED_W-1:0], 3)})
    else $error("control word read back wrong");

  a_unmapped_zero: assert property (@(posedge mclk) disable iff (reset)
    reg_rd && !hit_ctl |=> reg_rdata == 32'h0000_0000)
    else $error("unmapped read not zero");

  a_idle_wakes: assert property (@(posedge mclk) disable iff (reset)
    !ctl_q.wake_select && idle_pulse |=> !receiver_muted)
    else $error("idle frame did not clear mute");

  sequence s_addr_frame(logic m);
    ctl_q.wake_select && rx_take && addr_match == m;
  endsequence

  a_match_wakes: assert property (@(posedge mclk) disable iff (reset)
    s_addr_frame(1'b1) |=> !receiver_muted)
    else $error("address match did not clear mute");

  a_mismatch_mutes: assert property (@(posedge mclk) disable iff (reset)
    s_addr_frame(1'b0) |=> receiver_muted)
    else $error("address mismatch did not set mute");

  a_break_clears: assert property (@(posedge mclk) disable iff (reset)
    break_done && !wr_ctl |=> !ctl_q.send_break_request)
    else $error("break bit not cleared");

  a_irq_parity: assert property (@(posedge mclk) disable iff (reset)
    ctl_q.unit_on && ctl_q.parity_fault_irq_on && flags.parity_fault_flag |=> irq)
    else $error("parity fault interrupt missing");

  a_irq_rx_over: assert property (@(posedge mclk) disable iff (reset)
    ctl_q.unit_on && ctl_q.rx_full_irq_on && flags.overflow_fault_flag |=> irq)
    else $error("overflow interrupt missing");

  a_unit_off_quiet: assert property (@(posedge mclk) disable iff (reset)
    !ctl_q.unit_on |-> !transmitter_active && !receiver_active && !break_send
      ##1 !irq)
    else $error("unit off but active");

  a_irq_cause: assert property (@(posedge mclk) disable iff (reset)
    irq |-> $past(pe_req || tb_req || td_req || rb_req || id_req))
    else $error("interrupt without cause");

endmodule

// [spcz_pkg.sv]
/*
  Shared constants and carriers for the serial port control register
  block: register offset, field positions, reset value and the packed
  structs that carry control fields and status flags between modules.
  Assumes a single 10 MHz clock domain and a word-wide register port.
*/
package spcz_pkg;

  // ----------------------------------------------------------------
  // Register map
  // ----------------------------------------------------------------
  localparam int          ADDR_W         = 8;        // Register port address width
  localparam logic [7:0]  OFS_CTL_ZERO   = 8'h0C;    // serial_control_zero offset
  localparam logic [31:0] CTL_ZERO_RESET = 32'h0000_0000;
  localparam int          CTL_USED_W     = 14;       // Implemented bits 13..0

  // ----------------------------------------------------------------
  // Field positions
  // ----------------------------------------------------------------
  localparam int POS_UNIT_ON   = 13;
  localparam int POS_LEN_NINE  = 12;
  localparam int POS_WAKE_SEL  = 11;
  localparam int POS_PARITY_ON = 10;
  localparam int POS_PAR_ODD   = 9;
  localparam int POS_MUTE      = 1;
  localparam int POS_BREAK     = 0;

  // ----------------------------------------------------------------
  // Frame layout
  // ----------------------------------------------------------------
  localparam int          DATA_W        = 9;         // Widest data word
  localparam int          ADDR_MATCH_W  = 4;         // Low bits compared for wake
  localparam logic [3:0]  FRAME_BITS_8  = 4'hA;      // Start + 8 data + stop
  localparam logic [3:0]  FRAME_BITS_9  = 4'hB;      // Start + 9 data + stop

  // Control fields, in register bit order from 13 down to 0
  typedef struct packed {
    logic unit_on;
    logic word_length_nine;
    logic wake_select;
    logic parity_on;
    logic parity_odd_select;
    logic parity_fault_irq_on;
    logic tx_buffer_free_irq_on;
    logic tx_done_irq_on;
    logic rx_full_irq_on;
    logic quiet_line_irq_on;
    logic transmitter_on;
    logic receiver_on;
    logic receiver_mute;
    logic send_break_request;
  } spcz_ctl_t;

  // Status flags kept by the shifter and flag logic outside
  typedef struct packed {
    logic parity_fault_flag;
    logic tx_buffer_free_flag;
    logic transfer_done_flag;
    logic rx_holding_full_flag;
    logic overflow_fault_flag;
    logic quiet_line_flag;
  } spcz_flags_t;

endpackage

// [spcz_parity.sv]
/*
  Transmit word former: latches a data word and, with parity on,
  replaces its top data bit by the computed parity bit.
  Assumes the load strobe is one cycle and the data stand beside it.
*/
`timescale 1ns/1ps
module spcz_parity
  import spcz_pkg::*;
(
  input  wire logic                        mclk,
  input  wire logic                        reset,
  input  wire logic                        parity_on,
  input  wire logic                        parity_odd_select,
  input  wire logic                        word_length_nine,
  input  wire logic                        load,
  input  wire logic [spcz_pkg::DATA_W-1:0] data_in,
  output logic      [spcz_pkg::DATA_W-1:0] word_out
);
  import spcz_pkg::*;

  // ----------------------------------------------------------------
  // Parity computation
  // ----------------------------------------------------------------
  logic [DATA_W-1:0] word_q;     // Formed word
  logic [DATA_W-1:0] word_d;     // Next formed word
  logic              sum_low8;   // XOR of the bits below an 8-bit MSB
  logic              sum_low9;   // XOR of the bits below a 9-bit MSB
  logic              par_bit;    // Parity bit to insert

  assign sum_low8 = ^data_in[6:0];
  assign sum_low9 = ^data_in[7:0];
  // Even parity makes the count of ones even; odd flips it
  assign par_bit  = (word_length_nine ? sum_low9 : sum_low8) ^ parity_odd_select;

  // MSB replacement depends on the word length
  always_comb begin
    word_d = data_in;
    if (parity_on && word_length_nine) begin
      word_d[8] = par_bit;
    end else if (parity_on) begin
      word_d[7] = par_bit;
    end
  end

  // Word register, only updated on load
  always_ff @(posedge mclk) begin
    if (reset) begin
      word_q <= '0;
    end else if (load) begin
      word_q <= word_d;
    end
  end

  assign word_out = word_q;

  // A loaded 8-bit word with even parity on has an even count of ones in bits 7..0
  a_even_parity_word: assert property (@(posedge mclk) disable iff (reset)
    load && parity_on && !parity_odd_select && !word_length_nine
    |=> ^word_out[7:0] == 1'b0)
    else $error("even parity word malformed");

endmodule

// [spcz_idle.sv]
/*
  Idle frame detector: counts bit ticks while the receive line stays
  high and pulses once when a whole frame time has passed.
  Assumes rx_line and bit_tick are synchronous to mclk.
*/
`timescale 1ns/1ps
module spcz_idle
  import spcz_pkg::*;
(
  input  wire logic       mclk,
  input  wire logic       reset,
  input  wire logic       enable,
  input  wire logic       word_length_nine,
  input  wire logic       rx_line,
  input  wire logic       bit_tick,
  output logic            idle_seen
);
  import spcz_pkg::*;

  // ----------------------------------------------------------------
  // State machine
  // ----------------------------------------------------------------
  typedef enum logic [2:0] {
    ST_ARMED = 3'b001,   // Waiting for high line to count
    ST_COUNT = 3'b010,   // Counting high bit times
    ST_SPENT = 3'b100    // Idle reported, wait for traffic
  } spcz_idle_t;

  spcz_idle_t state_q;      // Current state
  spcz_idle_t state_d;      // Next state
  logic [3:0] count_q;      // High bit times so far
  logic [3:0] count_d;      // Next count
  logic [3:0] frame_len;    // Bit times in one frame

  assign frame_len = word_length_nine ? FRAME_BITS_9 : FRAME_BITS_8;

  // A low line restarts the count; one report per idle stretch
  always_comb begin
    state_d   = state_q;
    count_d   = count_q;
    idle_seen = 1'b0;
    unique case (state_q)
      ST_ARMED: begin
        count_d = '0;
        if (enable && rx_line) begin
          state_d = ST_COUNT;
        end
      end
      ST_COUNT: begin
        if (!enable || !rx_line) begin
          state_d = ST_ARMED;
        end else if (bit_tick && count_q == frame_len - 4'h1) begin
          idle_seen = 1'b1;
          state_d   = ST_SPENT;
        end else if (bit_tick) begin
          count_d = count_q + 4'h1;
        end
      end
      ST_SPENT: begin
        if (!enable || !rx_line) begin
          state_d = ST_ARMED;
        end
      end
      default: begin
        state_d = ST_ARMED;
      end
    endcase
  end

  // State and count registers
  always_ff @(posedge mclk) begin
    if (reset) begin
      state_q <= ST_ARMED;
      count_q <= '0;
    end else begin
      state_q <= state_d;
      count_q <= count_d;
    end
  end

  // An idle report needs the line high in its own cycle and in the cycle before
  a_idle_line_high: assert property (@(posedge mclk) disable iff (reset)
    idle_seen |-> rx_line && enable && $past(rx_line))
    else $error("idle reported on busy line");

endmodule

// [spcz_node_model.sv]
/*
  Remote serial node model: free running bit tick, receive line with
  frames toward the block, and the answer to a break request.
  Assumes one mclk domain; everything changes just after rising edges.
*/
`timescale 1ns/1ps
module spcz_node_model
  import spcz_pkg::*;
#(
  parameter int BRK_CYC = 40                          // Break length, 10 ticks of 4 clocks
)(
  input  wire logic                        mclk,
  input  wire logic                        break_send,
  output logic                             rx_line,
  output logic                             bit_tick,
  output logic                             rx_frame_valid,
  output logic      [spcz_pkg::DATA_W-1:0] rx_frame_data,
  output logic                             break_done
);
  logic [1:0] tick_q = 2'h0;                          // Baud prescaler
  int         brk_q  = 0;                             // Clocks spent on a break
  initial begin
    rx_line = 1'b1;
    bit_tick = 1'b0;
    rx_frame_valid = 1'b0;
    rx_frame_data = '0;
    break_done = 1'b0;
  end
  // ----------------------------------------
  // Baud tick, never stops like a real divider
  // ----------------------------------------
  always @(posedge mclk) begin
    tick_q <= tick_q + 2'h1;
    bit_tick <= (tick_q == 2'h3);
  end
  // One done pulse per break, after a whole frame time
  always @(posedge mclk) begin
    brk_q <= (break_send && !break_done) ? brk_q + 1 : 0;
    break_done <= break_send && !break_done && (brk_q == BRK_CYC - 1);
  end
  // Line low for a frame, then the frame pulse; stale data is inverted
  task automatic send_frame(input logic [8:0] d);
    @(posedge mclk);
    rx_line <= 1'b0;
    repeat (40) @(posedge mclk);
    rx_line <= 1'b1;
    rx_frame_valid <= 1'b1;
    rx_frame_data <= d;
    @(posedge mclk);
    rx_frame_valid <= 1'b0;
    rx_frame_data <= ~d;
  endtask
endmodule

// [spcz_ctl_tb_top.sv]
/*
  Self-checking bench for the control register block: register table,
  enables, interrupts, parity word, mute wake and break.
  Assumes the node model drives the line side.
*/
`timescale 1ns/1ps
module spcz_ctl_tb_top;
  import spcz_pkg::*;
  typedef struct packed {
    logic [31:0] w;                                   // Value written
    logic [4:0]  o;                                   // tx, rx, nine, parity, odd
  } spcz_row_t;
  logic mclk = 1'b0, reset = 1'b1, reg_wr = 1'b0, reg_rd = 1'b0, tx_data_load = 1'b0;
  logic [7:0] reg_addr = 8'h00;
  logic [31:0] reg_wdata = 32'h0, reg_rdata, rv;
  spcz_flags_t flags = '0;
  logic [3:0] node_address = 4'h5;
  logic [8:0] tx_data_in = 9'h0B5, tx_word, rx_frame_data, e, m;
  logic rx_line, bit_tick, rx_frame_valid, break_done, break_send, transmitter_active;
  logic receiver_active, receiver_muted, word_length_nine, parity_on, parity_odd_select;
  logic idle_frame_seen, irq;
  int mismatches = 0, num_checks = 0, idles = 0, n, eb;
  spcz_row_t rows [5] = '{'{32'h2008, 5'h10}, '{32'h2004, 5'h08}, '{32'h000E, 5'h00},
                         '{32'h3600, 5'h07}, '{32'h3FF0, 5'h07}};
  always #50 mclk = ~mclk;                            // 10 MHz
  always @(posedge mclk) if (idle_frame_seen === 1'b1) idles <= idles + 1;
  spcz_ctl spcz_ctl_i (.mclk(mclk), .reset(reset), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .flags(flags),
    .node_address(node_address), .rx_line(rx_line), .bit_tick(bit_tick),
    .rx_frame_valid(rx_frame_valid), .rx_frame_data(rx_frame_data),
    .tx_data_load(tx_data_load), .tx_data_in(tx_data_in), .tx_word(tx_word),
    .break_done(break_done), .break_send(break_send), .transmitter_active(transmitter_active),
    .receiver_active(receiver_active), .receiver_muted(receiver_muted),
    .word_length_nine(word_length_nine), .parity_on(parity_on),
    .parity_odd_select(parity_odd_select), .idle_frame_seen(idle_frame_seen), .irq(irq));
  spcz_node_model spcz_node_model_i (.mclk(mclk), .break_send(break_send), .rx_line(rx_line),
    .bit_tick(bit_tick), .rx_frame_valid(rx_frame_valid), .rx_frame_data(rx_frame_data),
    .break_done(break_done));
  // ----------------------------------------
  // Bus cycles and comparison
  // ----------------------------------------
  // Every value written keeps bits 31:14 at zero
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge mclk);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1'b1;
    @(posedge mclk);
    reg_wr <= 1'b0;
    #1;
  endtask
  // Read data stand only in the cycle after the strobe
  task automatic rd(input logic [7:0] a);
    @(posedge mclk);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge mclk);
    reg_rd <= 1'b0;
    #1 rv = reg_rdata;
  endtask
  task automatic chk(input string nm, input logic [31:0] ex, input logic [31:0] sn);
    num_checks++;
    if (sn !== ex) begin
      mismatches++;
      $display("MISMATCH %s expected %h seen %h", nm, ex, sn);
    end
  endtask
  task automatic close_out;
    $display("checks %0d mismatches %0d", num_checks, mismatches);
    if (mismatches == 0 && num_checks > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask
  // ----------------------------------------
  // Main sequence
  // ----------------------------------------
  initial begin
    repeat (20) @(posedge mclk);
    reset <= 1'b0;
    rd(8'h0C);
    chk("reset value", 32'h0, rv);
    chk("reset irq", 32'h0, {31'h0, irq});
    foreach (rows[i]) begin
      wr(8'h0C, rows[i].w);
      chk("enables", {27'h0, rows[i].o}, {27'h0, transmitter_active, receiver_active,
          word_length_nine, parity_on, parity_odd_select});
      rd(8'h0C);
      chk("readback", rows[i].w & 32'h3FFF, rv);
    end
    wr(8'h10, 32'h3FFF);
    rd(8'h0C);
    chk("other offset", 32'h3FF0, rv);
    rd(8'h08);
    chk("unmapped", 32'h0, rv);
    // Each cause with its enable, enable off, then unit off
    for (int i = 0; i < 6; i++) begin
      eb = (i < 2) ? 4 + i : 3 + i;
      @(posedge mclk);
      flags <= spcz_flags_t'(6'(1 << i));
      wr(8'h0C, 32'h2000 | (32'h1 << eb));
      repeat (2) @(posedge mclk);
      #1 chk("irq on", 32'h1, {31'h0, irq});
      wr(8'h0C, 32'h3FF0 & ~(32'h1 << eb));
      repeat (2) @(posedge mclk);
      #1 chk("irq masked", 32'h0, {31'h0, irq});
      wr(8'h0C, 32'h1 << eb);
      repeat (2) @(posedge mclk);
      #1 chk("irq unit off", 32'h0, {31'h0, irq});
    end
    @(posedge mclk);
    flags <= '0;
    // Parity replaces the top data bit, all four modes
    for (int k = 0; k < 4; k++) begin
      wr(8'h0C, 32'h2408 | (32'(k[1]) << 12) | (32'(k[0]) << 9));
      @(posedge mclk);
      tx_data_load <= 1'b1;
      @(posedge mclk);
      tx_data_load <= 1'b0;
      #1;
      e = k[1] ? {^tx_data_in[7:0] ^ k[0], tx_data_in[7:0]}
               : {tx_data_in[8], ^tx_data_in[6:0] ^ k[0], tx_data_in[6:0]};
      m = k[1] ? 9'h1FF : 9'h0FF;
      chk("tx word", {23'h0, e & m}, {23'h0, tx_word & m});
    end
    // Address wake: match wakes, mismatch mutes
    wr(8'h0C, 32'h2806);
    chk("sw mute", 32'h1, {31'h0, receiver_muted});
    spcz_node_model_i.send_frame(9'h035);
    #1 chk("addr match", 32'h0, {31'h0, receiver_muted});
    spcz_node_model_i.send_frame(9'h036);
    #1 chk("addr miss", 32'h1, {31'h0, receiver_muted});
    // Idle wake: frames ignored, a whole quiet frame time wakes
    wr(8'h0C, 32'h2006);
    idles = 0;
    spcz_node_model_i.send_frame(9'h035);
    #1 chk("idle mode frame", 32'h1, {31'h0, receiver_muted});
    n = 0;
    while (receiver_muted !== 1'b0 && n < 200) begin
      @(posedge mclk);
      #1 n++;
    end
    // Ten ticks of four clocks after the line rises, tick phase unknown
    chk("idle wake", 32'h1, {31'h0, n >= 37 && n <= 40});
    chk("idle pulses", 32'h1, 32'(idles));
    // Break: one frame, then the bit clears itself
    wr(8'h0C, 32'h2009);
    chk("break send", 32'h1, {31'h0, break_send});
    n = 0;
    while (break_send !== 1'b0 && n < 100) begin
      @(posedge mclk);
      #1 n++;
    end
    // Model ends the break after 40 clocks; the bit drops one edge later
    chk("break time", 32'd41, 32'(n));
    rd(8'h0C);
    chk("break cleared", 32'h2008, rv);
    close_out();
  end
endmodule
